// File: rtl/hps_regs.svh
`ifndef HPS_REGS_SVH
`define HPS_REGS_SVH

`define HPS_HOST_PORT_STATUS_0_ADDR 8'h08
`define HPS_HOST_PORT_STATUS_0_RST 13'h0040
`define HPS_FLAG_W 13

`define HPS_B_CTRL_PROT 12
`define HPS_B_TX_CSEQ 11
`define HPS_B_STAMP_C 10
`define HPS_B_STAMP_A 8
`define HPS_B_PHY_IRQ 7
`define HPS_B_RESET_DONE 6
`define HPS_B_HDR_PAR 5
`define HPS_B_EARLY_CS 4
`define HPS_B_RX_OVF 3
`define HPS_B_TX_UNDR 2
`define HPS_B_TX_OVF 1
`define HPS_B_TX_PROTO 0

`define HPS_LEV_HDR 0
`define HPS_LEV_CS 1
`define HPS_LEV_CTRL 2
`define HPS_LEV_PROTO 3
`define HPS_LEV_W 4

`define HPS_TX_FIFO_MIN_BYTES 4096
`define HPS_HOST_MIN_RATE_MBPS 10

`endif

// File: rtl/hps_pkg.sv
`default_nettype none
package hps_pkg;
  // one chunk header as seen by the link-side protocol engine
  typedef struct packed {
    logic valid;
    logic sv;
    logic ev;
    logic dv;
  } hps_chunk_t;

  typedef enum logic {
    HPS_GATE_OPEN = 1'b0,
    HPS_GATE_DROP = 1'b1
  } hps_gate_t;

  typedef enum logic {
    HPS_CH_IDLE = 1'b0,
    HPS_CH_FRAME = 1'b1
  } hps_chunk_st_t;
endpackage : hps_pkg
`default_nettype wire

// File: rtl/hps_sync.sv
`default_nettype none
module hps_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } hps_sync_state_t;

  hps_sync_state_t s_q;
  hps_sync_state_t s_d;

  always_comb
  begin
    s_d.meta = d_i;
    s_d.sync = s_q.meta;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign q_o = s_q.sync;
endmodule : hps_sync
`default_nettype wire

// File: rtl/hps_evt_xfer.sv
`default_nettype none
// two pulses spaced closer than a destination cycle cancel in the toggle and are both lost
module hps_evt_xfer #(
  parameter int W = 1
) (
  input wire logic src_clk_i,
  input wire logic src_rst_i,
  input wire logic [W-1:0] src_pulse_i,
  input wire logic dst_clk_i,
  input wire logic dst_rst_i,
  output logic [W-1:0] dst_pulse_o
);
  typedef struct packed {
    logic [W-1:0] tog;
  } hps_src_state_t;

  typedef struct packed {
    logic [W-1:0] seen;
    logic [W-1:0] pulse;
    logic [1:0] settle;
  } hps_dst_state_t;

  hps_src_state_t src_q;
  hps_src_state_t src_d;
  hps_dst_state_t dst_q;
  hps_dst_state_t dst_d;
  logic [W-1:0] tog_sync;

  always_comb
  begin
    src_d.tog = src_q.tog ^ src_pulse_i;
  end

  always_ff @(posedge src_clk_i)
  begin
    if (src_rst_i)
    begin
      src_q <= '0;
    end
    else
    begin
      src_q <= src_d;
    end
  end

  hps_sync #(.W(W)) u_sync (
    .clk_i(dst_clk_i),
    .rst_i(dst_rst_i),
    .d_i(src_q.tog),
    .q_o(tog_sync)
  );

  // a reset of this side alone would take the far toggles for fresh events;
  // events landing in the first cycles after it are lost
  always_comb
  begin
    dst_d.seen = tog_sync;
    dst_d.settle = dst_q.settle;
    dst_d.pulse = '0;
    if (dst_q.settle == 2'h3)
    begin
      dst_d.pulse = tog_sync ^ dst_q.seen;
    end
    else
    begin
      dst_d.settle = dst_q.settle + 2'h1;
    end
  end

  always_ff @(posedge dst_clk_i)
  begin
    if (dst_rst_i)
    begin
      dst_q <= '0;
    end
    else
    begin
      dst_q <= dst_d;
    end
  end

  assign dst_pulse_o = dst_q.pulse;
endmodule : hps_evt_xfer
`default_nettype wire

// File: rtl/hps_status.sv
`include "hps_regs.svh"
`default_nettype none
module hps_status #(
  parameter int LEN_W = 16,
  parameter int TX_FIFO_BYTES = `HPS_TX_FIFO_MIN_BYTES
) (
  // system clock and reset
  input wire logic CLK_SYS_I,
  input wire logic SYS_RST_I,
  // register access from the host port engine
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [31:0] REG_WDATA_I,
  output logic [31:0] REG_RDATA_O,
  output logic REG_RVALID_O,
  // mode and config levels
  input wire logic MODE_FRAMED_I,
  input wire logic CTRL_PROTECT_EN_I,
  input wire logic CUT_THROUGH_I,
  input wire logic PHY_IRQ_UNMASK_I,
  // system-side events
  input wire logic TX_FCS_ERR_I,
  input wire logic [2:0] TS_CAPTURE_I,
  input wire logic RX_BUF_OVF_I,
  input wire logic TX_UNDERRUN_I,
  input wire logic PHY_IRQ_I,
  // generic-mode frame bookkeeping
  input wire logic GEN_LEN_WR_I,
  input wire logic [LEN_W-1:0] GEN_LEN_I,
  input wire logic GEN_DATA_WR_I,
  input wire logic [2:0] GEN_DATA_BYTES_I,
  // host transmit FIFO write gate
  input wire logic TX_WR_VALID_I,
  input wire logic TX_WR_SOF_I,
  input wire logic TX_FIFO_FULL_I,
  output logic TX_WR_ACCEPT_O,
  output logic TX_FRAME_DROP_O,
  output logic TX_ABORT_O,
  // host-facing indications
  output logic HOST_IRQ_O,
  output logic FOOTER_EXT_STATUS_O,
  // link clock domain
  input wire logic LINK_CLK_I,
  input wire logic LINK_RST_I,
  input wire hps_pkg::hps_chunk_t LINK_CHUNK_I,
  input wire logic LINK_HDR_PARITY_ERR_I,
  input wire logic LINK_CS_EARLY_I,
  input wire logic LINK_CTRL_PROT_ERR_I
);
  import hps_pkg::*;

  typedef struct packed {
    hps_chunk_st_t st;
    logic [`HPS_LEV_W-1:0] ev;
  } hps_link_state_t;

  typedef struct packed {
    logic [`HPS_FLAG_W-1:0] flags;
    logic phy_por;
    hps_gate_t gate;
    logic [LEN_W-1:0] gen_remain;
    logic [31:0] rdata;
    logic rvalid;
    logic frame_drop;
    logic tx_abort;
  } hps_sys_state_t;

  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == `HPS_HOST_PORT_STATUS_0_ADDR);
  endfunction : addr_hit

  hps_link_state_t lnk_q;
  hps_link_state_t lnk_d;
  hps_sys_state_t sys_q;
  hps_sys_state_t sys_d;
  logic [`HPS_LEV_W-1:0] lev;
  logic phy_irq_s;
  logic [`HPS_FLAG_W-1:0] set_v;
  logic [`HPS_FLAG_W-1:0] clr_v;
  logic wr_hit;
  logic rd_hit;
  logic ovf_ev;
  logic gen_err;

  // link side: chunk order checking runs where the chunks arrive
  always_comb
  begin
    lnk_d = lnk_q;
    lnk_d.ev = '0;
    lnk_d.ev[`HPS_LEV_HDR] = LINK_HDR_PARITY_ERR_I;
    lnk_d.ev[`HPS_LEV_CS] = LINK_CS_EARLY_I;
    lnk_d.ev[`HPS_LEV_CTRL] = LINK_CTRL_PROT_ERR_I;
    if (LINK_CHUNK_I.valid && LINK_CHUNK_I.dv)
    begin
      if (lnk_q.st == HPS_CH_IDLE && !LINK_CHUNK_I.sv)
      begin
        lnk_d.ev[`HPS_LEV_PROTO] = 1'b1;
      end
      if (lnk_q.st == HPS_CH_FRAME && LINK_CHUNK_I.sv && !LINK_CHUNK_I.ev)
      begin
        lnk_d.ev[`HPS_LEV_PROTO] = 1'b1;
      end
      if (LINK_CHUNK_I.sv && !LINK_CHUNK_I.ev)
      begin
        lnk_d.st = HPS_CH_FRAME;
      end
      else if (LINK_CHUNK_I.ev)
      begin
        lnk_d.st = HPS_CH_IDLE;
      end
    end
  end

  always_ff @(posedge LINK_CLK_I)
  begin
    if (LINK_RST_I)
    begin
      lnk_q <= '{st: HPS_CH_IDLE, ev: '0};
    end
    else
    begin
      lnk_q <= lnk_d;
    end
  end

  hps_evt_xfer #(.W(`HPS_LEV_W)) u_xfer (
    .src_clk_i(LINK_CLK_I),
    .src_rst_i(LINK_RST_I),
    .src_pulse_i(lnk_q.ev),
    .dst_clk_i(CLK_SYS_I),
    .dst_rst_i(SYS_RST_I),
    .dst_pulse_o(lev)
  );

  // the PHY interrupt comes from another block's pin
  hps_sync #(.W(1)) u_phy_sync (
    .clk_i(CLK_SYS_I),
    .rst_i(SYS_RST_I),
    .d_i(PHY_IRQ_I),
    .q_o(phy_irq_s)
  );

  assign wr_hit = REG_WR_I && addr_hit(REG_ADDR_I);
  assign rd_hit = REG_RD_I && addr_hit(REG_ADDR_I);

  // a full FIFO at a new start keeps dropping: the new frame would overflow too
  assign ovf_ev = TX_WR_VALID_I && TX_FIFO_FULL_I && (sys_q.gate == HPS_GATE_OPEN || TX_WR_SOF_I);
  assign TX_WR_ACCEPT_O = TX_WR_VALID_I && !TX_FIFO_FULL_I &&
    (sys_q.gate == HPS_GATE_OPEN || TX_WR_SOF_I);
  assign gen_err = !MODE_FRAMED_I && GEN_LEN_WR_I && (sys_q.gen_remain != '0);

  always_comb
  begin
    set_v = '0;
    set_v[`HPS_B_CTRL_PROT] = lev[`HPS_LEV_CTRL] && MODE_FRAMED_I && CTRL_PROTECT_EN_I;
    set_v[`HPS_B_TX_CSEQ] = TX_FCS_ERR_I;
    set_v[`HPS_B_STAMP_C:`HPS_B_STAMP_A] = TS_CAPTURE_I;
    set_v[`HPS_B_HDR_PAR] = lev[`HPS_LEV_HDR] && MODE_FRAMED_I;
    set_v[`HPS_B_EARLY_CS] = lev[`HPS_LEV_CS] || set_v[`HPS_B_CTRL_PROT];
    set_v[`HPS_B_RX_OVF] = RX_BUF_OVF_I;
    set_v[`HPS_B_TX_UNDR] = TX_UNDERRUN_I && CUT_THROUGH_I;
    set_v[`HPS_B_TX_OVF] = ovf_ev;
    set_v[`HPS_B_TX_PROTO] = (lev[`HPS_LEV_PROTO] && MODE_FRAMED_I) || gen_err;
    clr_v = wr_hit ? REG_WDATA_I[`HPS_FLAG_W-1:0] : '0;
    clr_v[`HPS_B_PHY_IRQ] = 1'b0;
  end

  always_comb
  begin
    sys_d = sys_q;
    sys_d.flags = (sys_q.flags & ~clr_v) | set_v;
    sys_d.flags[`HPS_B_PHY_IRQ] = phy_irq_s || sys_q.phy_por;
    // power-up indication lasts until the host has seen it once
    // a read that has not yet shown the bit must not retire it
    sys_d.phy_por = sys_q.phy_por && !(rd_hit && sys_q.flags[`HPS_B_PHY_IRQ]);
    sys_d.frame_drop = 1'b0;
    sys_d.tx_abort = TX_UNDERRUN_I && CUT_THROUGH_I;
    unique case (sys_q.gate)
      HPS_GATE_OPEN:
      begin
        if (ovf_ev)
        begin
          sys_d.gate = HPS_GATE_DROP;
          sys_d.frame_drop = 1'b1;
        end
      end
      HPS_GATE_DROP:
      begin
        if (TX_WR_ACCEPT_O)
        begin
          sys_d.gate = HPS_GATE_OPEN;
        end
      end
    endcase
    if (!MODE_FRAMED_I && GEN_LEN_WR_I)
    begin
      sys_d.gen_remain = GEN_LEN_I;
    end
    else if (!MODE_FRAMED_I && GEN_DATA_WR_I)
    begin
      if (sys_q.gen_remain > LEN_W'(GEN_DATA_BYTES_I))
      begin
        sys_d.gen_remain = sys_q.gen_remain - LEN_W'(GEN_DATA_BYTES_I);
      end
      else
      begin
        sys_d.gen_remain = '0;
      end
    end
    sys_d.rvalid = REG_RD_I;
    sys_d.rdata = '0;
    if (rd_hit)
    begin
      sys_d.rdata = {{(32 - `HPS_FLAG_W){1'b0}}, sys_q.flags};
    end
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (SYS_RST_I)
    begin
      sys_q <= '{flags: `HPS_HOST_PORT_STATUS_0_RST, phy_por: 1'b1, gate: HPS_GATE_OPEN,
                 gen_remain: '0, rdata: '0, rvalid: 1'b0, frame_drop: 1'b0, tx_abort: 1'b0};
    end
    else
    begin
      sys_q <= sys_d;
    end
  end

  assign REG_RDATA_O = sys_q.rdata;
  assign REG_RVALID_O = sys_q.rvalid;
  assign TX_FRAME_DROP_O = sys_q.frame_drop;
  assign TX_ABORT_O = sys_q.tx_abort;
  // phy term stays masked unless the mask path opens it
  assign HOST_IRQ_O = sys_q.flags[`HPS_B_RESET_DONE] ||
    (sys_q.flags[`HPS_B_PHY_IRQ] && PHY_IRQ_UNMASK_I);
  assign FOOTER_EXT_STATUS_O = sys_q.flags[`HPS_B_RESET_DONE];

  a_ctrl_protect_err_also_early_select_release_err: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
    $rose(sys_q.flags[`HPS_B_CTRL_PROT]) |-> sys_q.flags[`HPS_B_EARLY_CS])
    else $error("protection error without early release flag");

  a_fcs_flag_set: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
    TX_FCS_ERR_I |=> sys_q.flags[`HPS_B_TX_CSEQ])
    else $error("check sequence error not flagged");

  a_fcs_no_abort: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
    (TX_FCS_ERR_I && !TX_UNDERRUN_I) |=> !TX_ABORT_O)
    else $error("check sequence error stopped transmission");

  a_stamp_c_sticky: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
    TS_CAPTURE_I[2] |=> sys_q.flags[`HPS_B_STAMP_C] ##1
    (sys_q.flags[`HPS_B_STAMP_C] || $past(wr_hit && REG_WDATA_I[`HPS_B_STAMP_C])))
    else $error("stamp slot c flag not held");

  a_phy_mirror: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
    (!sys_q.phy_por && $past(!sys_q.phy_por)) |-> sys_q.flags[`HPS_B_PHY_IRQ] == $past(phy_irq_s))
    else $error("phy interrupt bit does not mirror the phy");

  a_phy_after_reset: assert property (@(posedge CLK_SYS_I)
    ($past(SYS_RST_I) && !SYS_RST_I) |=> sys_q.flags[`HPS_B_PHY_IRQ] ##1 sys_q.flags[`HPS_B_PHY_IRQ])
    else $error("phy interrupt bit not asserted after reset");

  a_reset_done_init: assert property (@(posedge CLK_SYS_I)
    ($past(SYS_RST_I) && !SYS_RST_I) |-> sys_q.flags[`HPS_B_RESET_DONE] && FOOTER_EXT_STATUS_O)
    else $error("reset done flag not set after reset");

  a_reset_done_irq: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
    sys_q.flags[`HPS_B_RESET_DONE] |-> HOST_IRQ_O)
    else $error("reset done without host interrupt");

  a_ext_clear: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
    (wr_hit && REG_WDATA_I[`HPS_B_RESET_DONE]) |=> !FOOTER_EXT_STATUS_O [*3])
    else $error("extended status not cleared with reset done");

  a_undr_gated: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
    (!sys_q.flags[`HPS_B_TX_UNDR] && !(TX_UNDERRUN_I && CUT_THROUGH_I)) |=> !sys_q.flags[`HPS_B_TX_UNDR])
    else $error("underrun flag without cut-through underrun");

  a_ovf_discard: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
    (ovf_ev && !TX_WR_SOF_I) ##1 (TX_WR_VALID_I && !TX_WR_SOF_I) |-> !TX_WR_ACCEPT_O)
    else $error("write accepted before next start of frame");

  a_fifo_size: assert property (@(posedge CLK_SYS_I)
    TX_FIFO_BYTES >= `HPS_TX_FIFO_MIN_BYTES)
    else $error("transmit fifo smaller than minimum");

  a_gen_proto: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
    (!MODE_FRAMED_I && GEN_LEN_WR_I && sys_q.gen_remain != '0) |=> sys_q.flags[`HPS_B_TX_PROTO])
    else $error("incomplete generic frame not flagged");

  a_zero_write_keeps: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
    (wr_hit && REG_WDATA_I[`HPS_FLAG_W-1:0] == '0) |=>
    (sys_q.flags[`HPS_B_RX_OVF] == $past(sys_q.flags[`HPS_B_RX_OVF]) || $past(RX_BUF_OVF_I)))
    else $error("zero write changed a flag");

  a_set_wins: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
    (RX_BUF_OVF_I && wr_hit && REG_WDATA_I[`HPS_B_RX_OVF]) |=> sys_q.flags[`HPS_B_RX_OVF])
    else $error("clear beat a set event");

  a_chunk_order: assert property (@(posedge LINK_CLK_I) disable iff (LINK_RST_I)
    (LINK_CHUNK_I.valid && LINK_CHUNK_I.dv && !LINK_CHUNK_I.sv && lnk_q.st == HPS_CH_IDLE)
    |=> lnk_q.ev[`HPS_LEV_PROTO])
    else $error("data chunk without start not caught");
endmodule : hps_status
`default_nettype wire

// File: verif/hps_host_model.sv
`default_nettype none
// host side of the link: chunk headers and link-side error strobes
module hps_host_model (
  // link clock
  input wire logic link_clk_i,
  // link-side outputs
  output var hps_pkg::hps_chunk_t chunk_o,
  output var logic hdr_par_err_o,
  output var logic cs_early_o,
  output var logic ctrl_prot_err_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    chunk_o = '0;
    {ctrl_prot_err_o, cs_early_o, hdr_par_err_o} = 3'h0;
  end
  // one link cycle per header, nothing shown between headers
  task send_chunk(input hps_pkg::hps_chunk_t c);
    @(posedge link_clk_i);
    #1;
    chunk_o = c;
    @(posedge link_clk_i);
    #1;
    chunk_o = '0;
  endtask : send_chunk
  // e: [0] parity, [1] early select release, [2] protection
  task send_err(input logic [2:0] e);
    @(posedge link_clk_i);
    #1;
    {ctrl_prot_err_o, cs_early_o, hdr_par_err_o} = e;
    @(posedge link_clk_i);
    #1;
    {ctrl_prot_err_o, cs_early_o, hdr_par_err_o} = 3'h0;
  endtask : send_err
endmodule : hps_host_model
`default_nettype wire

// File: verif/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import hps_pkg::*;
  logic CLK_SYS_I, SYS_RST_I, REG_WR_I, REG_RD_I, MODE_FRAMED_I, CTRL_PROTECT_EN_I, CUT_THROUGH_I;
  logic PHY_IRQ_UNMASK_I, TX_FCS_ERR_I, RX_BUF_OVF_I, TX_UNDERRUN_I, PHY_IRQ_I, GEN_LEN_WR_I;
  logic GEN_DATA_WR_I, TX_WR_VALID_I, TX_WR_SOF_I, TX_FIFO_FULL_I, LINK_CLK_I, LINK_RST_I;
  logic REG_RVALID_O, TX_WR_ACCEPT_O, TX_FRAME_DROP_O, TX_ABORT_O, HOST_IRQ_O, FOOTER_EXT_STATUS_O;
  logic LINK_HDR_PARITY_ERR_I, LINK_CS_EARLY_I, LINK_CTRL_PROT_ERR_I;
  logic [7:0] REG_ADDR_I;
  logic [31:0] REG_WDATA_I, REG_RDATA_O;
  logic [2:0] TS_CAPTURE_I, GEN_DATA_BYTES_I;
  logic [15:0] GEN_LEN_I;
  hps_chunk_t LINK_CHUNK_I;
  int n_fail = 0;
  int samples_checked = 0;
  int cyc = 0;

  hps_status #(.LEN_W(16), .TX_FIFO_BYTES(4096)) dut (
    .CLK_SYS_I, .SYS_RST_I, .REG_WR_I, .REG_RD_I, .REG_ADDR_I, .REG_WDATA_I, .REG_RDATA_O, .REG_RVALID_O,
    .MODE_FRAMED_I, .CTRL_PROTECT_EN_I, .CUT_THROUGH_I, .PHY_IRQ_UNMASK_I, .TX_FCS_ERR_I, .TS_CAPTURE_I,
    .RX_BUF_OVF_I, .TX_UNDERRUN_I, .PHY_IRQ_I, .GEN_LEN_WR_I, .GEN_LEN_I, .GEN_DATA_WR_I, .GEN_DATA_BYTES_I,
    .TX_WR_VALID_I, .TX_WR_SOF_I, .TX_FIFO_FULL_I, .TX_WR_ACCEPT_O, .TX_FRAME_DROP_O, .TX_ABORT_O,
    .HOST_IRQ_O, .FOOTER_EXT_STATUS_O, .LINK_CLK_I, .LINK_RST_I, .LINK_CHUNK_I, .LINK_HDR_PARITY_ERR_I,
    .LINK_CS_EARLY_I, .LINK_CTRL_PROT_ERR_I);

  hps_host_model u_host (.link_clk_i(LINK_CLK_I), .chunk_o(LINK_CHUNK_I), .hdr_par_err_o(LINK_HDR_PARITY_ERR_I),
    .cs_early_o(LINK_CS_EARLY_I), .ctrl_prot_err_o(LINK_CTRL_PROT_ERR_I));

  initial
  begin
    CLK_SYS_I = 0;
    forever #2 CLK_SYS_I = ~CLK_SYS_I;
  end
  // odd offset keeps the link edges off the system edges
  initial
  begin
    LINK_CLK_I = 0;
    #1.3;
    forever #3 LINK_CLK_I = ~LINK_CLK_I;
  end

  task final_report;
    if (n_fail == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report

  always @(posedge CLK_SYS_I)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      final_report();
    end
  end

  task ticks(input int n);
    repeat (n)
    begin
      @(posedge CLK_SYS_I);
      #1;
    end
  endtask : ticks
  task chk32(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t status got %h exp %h", $time, got, exp);
    end
  endtask : chk32
  task chk1(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t flag got %b exp %b", $time, got, exp);
    end
  endtask : chk1
  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    REG_ADDR_I = a;
    REG_RD_I = 1;
    ticks(1);
    REG_RD_I = 0;
    chk1(REG_RVALID_O, 1);
    chk32(REG_RDATA_O, exp);
    ticks(1);
  endtask : rd_chk
  task wr(input logic [31:0] d);
    REG_ADDR_I = 8'h08;
    REG_WDATA_I = d;
    REG_WR_I = 1;
    ticks(1);
    REG_WR_I = 0;
    ticks(1);
  endtask : wr
  task gen_len;
    GEN_LEN_WR_I = 1;
    ticks(1);
    GEN_LEN_WR_I = 0;
    ticks(1);
  endtask : gen_len

  task t_reset;
    chk1(HOST_IRQ_O, 1);
    chk1(FOOTER_EXT_STATUS_O, 1);
    // phy bit shows one cycle after release
    ticks(1);
    rd_chk(8'h08, 32'h0C0);
    rd_chk(8'h10, 32'h0);
    wr(32'h0);
    rd_chk(8'h08, 32'h040);
    wr(32'hFFFF_E040);
    ticks(1);
    chk1(HOST_IRQ_O, 0);
    chk1(FOOTER_EXT_STATUS_O, 0);
    rd_chk(8'h08, 32'h0);
  endtask : t_reset

  task t_flags;
    logic [31:0] e;
    for (int k = 0; k < 5; k++)
    begin
      e = (k == 0) ? 32'h800 : (k == 4) ? 32'h008 : 32'h100 << (k - 1);
      TX_FCS_ERR_I = (k == 0);
      TS_CAPTURE_I = (k > 0 && k < 4) ? 3'h1 << (k - 1) : 3'h0;
      RX_BUF_OVF_I = (k == 4);
      ticks(1);
      {TX_FCS_ERR_I, TS_CAPTURE_I, RX_BUF_OVF_I} = 5'h00;
      chk1(TX_ABORT_O, 0);
      ticks(3);
      rd_chk(8'h08, e);
      wr(~e & 32'h1F3F);
      rd_chk(8'h08, e);
      wr(e);
      rd_chk(8'h08, 32'h0);
    end
  endtask : t_flags

  task t_underrun;
    for (int m = 0; m < 2; m++)
    begin
      CUT_THROUGH_I = (m == 1);
      TX_UNDERRUN_I = 1;
      ticks(1);
      TX_UNDERRUN_I = 0;
      chk1(TX_ABORT_O, m == 1);
      rd_chk(8'h08, (m == 1) ? 32'h004 : 32'h0);
      wr(32'h004);
    end
    CUT_THROUGH_I = 0;
  endtask : t_underrun

  task t_overflow;
    // host writes without checking space first
    TX_WR_VALID_I = 1;
    TX_FIFO_FULL_I = 1;
    #1;
    chk1(TX_WR_ACCEPT_O, 0);
    ticks(1);
    chk1(TX_FRAME_DROP_O, 1);
    TX_FIFO_FULL_I = 0;
    #1;
    chk1(TX_WR_ACCEPT_O, 0);
    ticks(1);
    TX_WR_SOF_I = 1;
    #1;
    chk1(TX_WR_ACCEPT_O, 1);
    ticks(1);
    TX_WR_SOF_I = 0;
    #1;
    chk1(TX_WR_ACCEPT_O, 1);
    ticks(1);
    TX_WR_VALID_I = 0;
    rd_chk(8'h08, 32'h002);
    wr(32'h002);
  endtask : t_overflow

  task t_generic;
    MODE_FRAMED_I = 0;
    GEN_LEN_I = 16'h0004;
    gen_len();
    GEN_DATA_BYTES_I = 3'h2;
    GEN_DATA_WR_I = 1;
    ticks(1);
    GEN_DATA_WR_I = 0;
    gen_len();
    rd_chk(8'h08, 32'h001);
    wr(32'h001);
    GEN_DATA_BYTES_I = 3'h4;
    GEN_DATA_WR_I = 1;
    ticks(2);
    GEN_DATA_WR_I = 0;
    GEN_LEN_I = 16'h0105;
    gen_len();
    rd_chk(8'h08, 32'h0);
    GEN_DATA_WR_I = 1;
    ticks(1);
    GEN_DATA_WR_I = 0;
    gen_len();
    u_host.send_err(3'h1);
    ticks(10);
    rd_chk(8'h08, 32'h001);
    wr(32'h001);
    MODE_FRAMED_I = 1;
  endtask : t_generic

  task t_link;
    logic [31:0] e;
    u_host.send_err(3'h4);
    ticks(10);
    rd_chk(8'h08, 32'h0);
    CTRL_PROTECT_EN_I = 1;
    for (int k = 0; k < 3; k++)
    begin
      e = (k == 0) ? 32'h020 : (k == 1) ? 32'h010 : 32'h1010;
      u_host.send_err(3'h1 << k);
      ticks(10);
      rd_chk(8'h08, e);
      wr(e);
    end
    u_host.send_chunk(4'h9);
    ticks(10);
    rd_chk(8'h08, 32'h001);
    wr(32'h001);
    u_host.send_chunk(4'hD);
    ticks(10);
    rd_chk(8'h08, 32'h0);
    u_host.send_chunk(4'hD);
    ticks(10);
    rd_chk(8'h08, 32'h001);
    u_host.send_chunk(4'hB);
    ticks(10);
    wr(32'h001);
    rd_chk(8'h08, 32'h0);
  endtask : t_link

  task t_phy;
    PHY_IRQ_I = 1;
    ticks(5);
    rd_chk(8'h08, 32'h080);
    chk1(HOST_IRQ_O, 0);
    PHY_IRQ_UNMASK_I = 1;
    ticks(2);
    chk1(HOST_IRQ_O, 1);
    wr(32'h080);
    rd_chk(8'h08, 32'h080);
    PHY_IRQ_I = 0;
    ticks(5);
    chk1(HOST_IRQ_O, 0);
    rd_chk(8'h08, 32'h0);
    PHY_IRQ_UNMASK_I = 0;
  endtask : t_phy

  task t_set_wins;
    // event and clear meet on one edge only, event low before the read
    RX_BUF_OVF_I = 1;
    ticks(1);
    REG_ADDR_I = 8'h08;
    REG_WDATA_I = 32'h008;
    REG_WR_I = 1;
    ticks(1);
    {REG_WR_I, RX_BUF_OVF_I} = 2'h0;
    ticks(1);
    rd_chk(8'h08, 32'h008);
    wr(32'h008);
    rd_chk(8'h08, 32'h0);
  endtask : t_set_wins

  initial
  begin
    {REG_WR_I, REG_RD_I, CTRL_PROTECT_EN_I, CUT_THROUGH_I, PHY_IRQ_UNMASK_I, TX_FCS_ERR_I} = 6'h00;
    {RX_BUF_OVF_I, TX_UNDERRUN_I, PHY_IRQ_I, GEN_LEN_WR_I, GEN_DATA_WR_I} = 5'h00;
    {TX_WR_VALID_I, TX_WR_SOF_I, TX_FIFO_FULL_I} = 3'h0;
    REG_ADDR_I = 8'h00;
    REG_WDATA_I = 32'h0;
    TS_CAPTURE_I = 3'h0;
    GEN_DATA_BYTES_I = 3'h0;
    GEN_LEN_I = 16'h0000;
    MODE_FRAMED_I = 1;
    SYS_RST_I = 1;
    LINK_RST_I = 1;
    ticks(8);
    SYS_RST_I = 0;
    LINK_RST_I = 0;
    t_reset();
    t_flags();
    t_underrun();
    t_overflow();
    t_generic();
    t_link();
    t_phy();
    t_set_wins();
    // system side alone: link toggles left odd must not show as events
    SYS_RST_I = 1;
    ticks(8);
    SYS_RST_I = 0;
    chk1(FOOTER_EXT_STATUS_O, 1);
    ticks(1);
    rd_chk(8'h08, 32'h0C0);
    ticks(4);
    rd_chk(8'h08, 32'h040);
    final_report();
  end
endmodule : tb_top
`default_nettype wire
